// ==== core/ipr_regs.sv ====
// Purpose: priority banks and level/vector status of the interrupt controller
// Assumes: core accepts a request with a one-cycle strobe carrying level and vector
// Notes: per-source effective priority is presented to the arbiter outside
`timescale 1ns/1ps
`default_nettype none
module ipr_regs #(
    parameter bit HAS_CAN = 1'b1
) (
    // clocking
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire ipr_pkg::ipr_bus_req_t bus_req,
    output logic [15:0] rdata,
    // core accepts an interrupt
    input wire logic accept_stb,
    input wire ipr_pkg::ipr_accept_t accept_info,
    // sources
    input wire logic [ipr_pkg::IPR_NSRC-1:0] src_req,
    // outputs to arbiter
    output logic [ipr_pkg::IPR_NSRC*3-1:0] src_priority,
    output logic [ipr_pkg::IPR_NSRC-1:0] src_pending,
    output logic [3:0] new_cpu_level,
    output logic [6:0] pending_vector_number
);
    import ipr_pkg::*;

    // ============================================================
    // state
    typedef struct packed {
        logic [15:0] rdata;
        logic [3:0] level;
        logic [6:0] vector;
    } ipr_state_t;
    ipr_state_t st_q;
    ipr_state_t st_d;

    logic [15:0] bank [IPR_NREG-1];
    logic [15:0] rd_mux;

    // ============================================================
    // priority banks
    localparam logic [15:0] BANK_MASK [IPR_NREG-1] = '{
        IPR_MASK_BANK5, IPR_MASK_BANK6, IPR_MASK_BANK7, IPR_MASK_BANK8,
        IPR_MASK_BANK9, IPR_MASK_BANK11, IPR_MASK_BANK15, IPR_MASK_BANK16,
        IPR_MASK_BANK17};

    genvar gi;
    generate
        for (gi = 0; gi < IPR_NREG - 1; gi++) begin : g_bank
            ipr_bank_reg #(.MASK(BANK_MASK[gi])) u_bank (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .wr_en(bus_req.wr && (bus_req.addr == 4'(gi))),
                .wdata(bus_req.wdata),
                .value(bank[gi])
            );
        end
    endgenerate

    // ============================================================
    // field extraction, one 3-bit field per source except spares 25 and 26
    logic [2:0] prio [IPR_NSRC];
    always_comb begin
        // bank 5: capture8, capture7, ext_irq1
        prio[0] = bank[0][14:12];
        prio[1] = bank[0][10:8];
        prio[2] = bank[0][2:0];
        // bank 6: timer4, compare4, compare3, dma_ch2
        prio[3] = bank[1][14:12];
        prio[4] = bank[1][10:8];
        prio[5] = bank[1][6:4];
        prio[6] = bank[1][2:0];
        // bank 7: serial2 tx, serial2 rx, ext_irq2, timer5
        prio[7] = bank[2][14:12];
        prio[8] = bank[2][10:8];
        prio[9] = bank[2][6:4];
        prio[10] = bank[2][2:0];
        // bank 8: can event, can rx, spi2 event, spi2 err
        prio[IPR_S_CAN_EVT] = bank[3][14:12];
        prio[IPR_S_CAN_RX] = bank[3][10:8];
        prio[11] = bank[3][6:4];
        prio[12] = bank[3][2:0];
        // bank 9: dma_ch3
        prio[13] = bank[4][2:0];
        // bank 11: dma_ch4, parallel port
        prio[14] = bank[5][10:8];
        prio[15] = bank[5][6:4];
        // bank 15: calendar, dma_ch5
        prio[16] = bank[6][10:8];
        prio[17] = bank[6][6:4];
        // bank 16: crc, serial2 err, serial1 err
        prio[18] = bank[7][14:12];
        prio[19] = bank[7][10:8];
        prio[22] = bank[7][6:4];
        // bank 17: can tx, dma_ch7, dma_ch6
        prio[IPR_S_CAN_TX] = bank[8][10:8];
        prio[23] = bank[8][6:4];
        prio[24] = bank[8][2:0];
        prio[25] = IPR_PRIO_OFF;
        prio[26] = IPR_PRIO_OFF;
    end

    // effective priority: can fields inert when the module is absent
    always_comb begin
        for (int i = 0; i < IPR_NSRC; i++) begin
            if (!HAS_CAN && (i == IPR_S_CAN_EVT || i == IPR_S_CAN_RX
                             || i == IPR_S_CAN_TX)) begin
                src_priority[i*3 +: 3] = IPR_PRIO_OFF;
            end else begin
                src_priority[i*3 +: 3] = prio[i];
            end
            // a zero field blocks the request entirely
            src_pending[i] = src_req[i] && (src_priority[i*3 +: 3] != IPR_PRIO_OFF);
        end
    end

    // ============================================================
    // read mux and status
    always_comb begin
        rd_mux = 16'h0000;
        if (bus_req.addr == IPR_A_STATUS) begin
            rd_mux = {4'h0, st_q.level, 1'b0, st_q.vector} & IPR_MASK_STATUS;
        end else if (bus_req.addr < IPR_A_STATUS) begin
            rd_mux = bank[bus_req.addr[3:0]];
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.rdata = bus_req.rd ? rd_mux : 16'h0000;
        // status follows the request the core just took; writes are ignored
        if (accept_stb) begin
            st_d.level = accept_info.level;
            st_d.vector = accept_info.vector;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign new_cpu_level = st_q.level;
    assign pending_vector_number = st_q.vector;
endmodule : ipr_regs
`default_nettype wire

// ==== core/ipr_pkg.sv ====
// Purpose: constants and carriers for the interrupt priority register block
// Assumes: 16-bit registers reached over a plain strobe port
// Notes: register indices are local choices
// ============================================================
// Summary of operation
// - three-bit priority, 111 highest, 001 lowest
// - priority 000 disables the source
// - reset loads priority level 4 everywhere
// - unimplemented bits read zero, ignore writes
// - fields at 14-12, 10-8, 6-4, 2-0
// - one field per listed source
// - can fields inert without can module
// - status read-only, level in bits 11-8
// - vector number in bits 6-0, 0 means 8
package ipr_pkg;
    localparam int IPR_NSRC = 28;
    localparam int IPR_NREG = 10;
    localparam logic [2:0] IPR_PRIO_RESET = 3'h4;
    localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
    localparam logic [15:0] IPR_STATUS_RESET = 16'h0000;
    // register indices
    localparam logic [3:0] IPR_A_BANK5 = 4'h0;
    localparam logic [3:0] IPR_A_BANK6 = 4'h1;
    localparam logic [3:0] IPR_A_BANK7 = 4'h2;
    localparam logic [3:0] IPR_A_BANK8 = 4'h3;
    localparam logic [3:0] IPR_A_BANK9 = 4'h4;
    localparam logic [3:0] IPR_A_BANK11 = 4'h5;
    localparam logic [3:0] IPR_A_BANK15 = 4'h6;
    localparam logic [3:0] IPR_A_BANK16 = 4'h7;
    localparam logic [3:0] IPR_A_BANK17 = 4'h8;
    localparam logic [3:0] IPR_A_STATUS = 4'h9;
    // field positions: lsb of each of the four slots
    localparam int IPR_SLOT_LSB0 = 0;
    localparam int IPR_SLOT_LSB1 = 4;
    localparam int IPR_SLOT_LSB2 = 8;
    localparam int IPR_SLOT_LSB3 = 12;
    localparam int IPR_LVL_LSB = 8;
    localparam int IPR_VEC_LSB = 0;
    // implemented-bit masks per bank
    localparam logic [15:0] IPR_MASK_BANK5 = 16'h7707;
    localparam logic [15:0] IPR_MASK_BANK6 = 16'h7777;
    localparam logic [15:0] IPR_MASK_BANK7 = 16'h7777;
    localparam logic [15:0] IPR_MASK_BANK8 = 16'h7777;
    localparam logic [15:0] IPR_MASK_BANK9 = 16'h0007;
    localparam logic [15:0] IPR_MASK_BANK11 = 16'h0770;
    localparam logic [15:0] IPR_MASK_BANK15 = 16'h0770;
    localparam logic [15:0] IPR_MASK_BANK16 = 16'h7770;
    localparam logic [15:0] IPR_MASK_BANK17 = 16'h0777;
    localparam logic [15:0] IPR_MASK_STATUS = 16'h0f7f;
    localparam logic [15:0] IPR_BANK_RESET = 16'h4444;
    // source numbering within the request vector
    localparam int IPR_S_CAN_EVT = 20;
    localparam int IPR_S_CAN_RX = 21;
    localparam int IPR_S_CAN_TX = 27;
    // vector number offset: code 0 is vector 8
    localparam int IPR_VEC_BASE = 8;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ipr_bus_req_t;

    typedef struct packed {
        logic [3:0] level;
        logic [6:0] vector;
    } ipr_accept_t;
endpackage : ipr_pkg

// ==== core/ipr_bank_reg.sv ====
// Purpose: one 16-bit priority bank with implemented-bit mask
// Assumes: synchronous reset, clock enable
// Notes: unimplemented bits never store a one
`timescale 1ns/1ps
`default_nettype none
module ipr_bank_reg #(
    parameter logic [15:0] MASK = 16'hffff
) (
    // clocking
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // write
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    // contents
    output logic [15:0] value
);
    import ipr_pkg::*;
    typedef struct packed {
        logic [15:0] val;
    } ipr_bank_state_t;
    ipr_bank_state_t st_q;
    ipr_bank_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            st_d.val = wdata & MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q.val <= IPR_BANK_RESET & MASK;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign value = st_q.val;
endmodule : ipr_bank_reg
`default_nettype wire

// ==== tb/ipr_regs_checker.sv ====
// Purpose: port-level assertions for ipr_regs
// Assumes: clk_en held high around reset
// Notes: bound to every ipr_regs instance
`timescale 1ns/1ps
`default_nettype none
module ipr_regs_checker #(
    parameter bit HAS_CAN = 1'b1
) (
    // clocking
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire ipr_pkg::ipr_bus_req_t bus_req,
    input wire logic [15:0] rdata,
    // core and sources
    input wire logic accept_stb,
    input wire ipr_pkg::ipr_accept_t accept_info,
    input wire logic [ipr_pkg::IPR_NSRC-1:0] src_req,
    input wire logic [ipr_pkg::IPR_NSRC*3-1:0] src_priority,
    input wire logic [ipr_pkg::IPR_NSRC-1:0] src_pending,
    input wire logic [3:0] new_cpu_level,
    input wire logic [6:0] pending_vector_number
);
    import ipr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // assertions
    a_reset_vals: assert property ($fell(sys_rst) |-> rdata == 16'h0
        && new_cpu_level == 4'h0 && pending_vector_number == 7'h0
        && src_priority[2:0] == IPR_PRIO_RESET)
        else $error("reset values wrong");
    a_status_take: assert property (accept_stb && clk_en |=>
        new_cpu_level == $past(accept_info.level)
        && pending_vector_number == $past(accept_info.vector))
        else $error("status not loaded on accept");
    a_status_hold: assert property (!accept_stb |=> $stable(new_cpu_level)
        && $stable(pending_vector_number)) else $error("status moved without accept");
    a_read_status: assert property (bus_req.rd && clk_en && !accept_stb
        && bus_req.addr == IPR_A_STATUS
        |=> rdata == {4'h0, $past(new_cpu_level), 1'b0, $past(pending_vector_number)})
        else $error("status read wrong");
    a_rdata_idle: assert property ($past(clk_en) && !$past(bus_req.rd)
        |-> rdata == 16'h0) else $error("read data outside read");
    a_gap_bits: assert property (bus_req.rd && clk_en && bus_req.addr < IPR_A_STATUS
        |=> (rdata & 16'h8888) == 16'h0) else $error("gap bit reads one");
    a_write_vis: assert property (bus_req.wr && clk_en && bus_req.addr == IPR_A_BANK5
        |=> src_priority[5:0] == {$past(bus_req.wdata[10:8]), $past(bus_req.wdata[14:12])})
        else $error("write not seen on priority");
    a_pend_gate: assert property ((src_pending & ~src_req) == '0
        && src_pending[0] == (src_req[0] && src_priority[2:0] != IPR_PRIO_OFF))
        else $error("pending not gated");
    a_can_inert: assert property (!HAS_CAN |-> src_priority[3*IPR_S_CAN_EVT+:6] == 6'h0
        && src_priority[3*IPR_S_CAN_TX+:3] == 3'h0 && !src_pending[IPR_S_CAN_RX])
        else $error("can source active");
endmodule : ipr_regs_checker

bind ipr_regs ipr_regs_checker #(.HAS_CAN(HAS_CAN)) chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata), .accept_stb(accept_stb),
    .accept_info(accept_info), .src_req(src_req), .src_priority(src_priority),
    .src_pending(src_pending), .new_cpu_level(new_cpu_level),
    .pending_vector_number(pending_vector_number));
`default_nettype wire

// ==== tb/ipr_core_model.sv ====
// Purpose: processor core and request sources facing ipr_regs
// Assumes: accept is a one-cycle strobe
// Notes: gap argument lets the core answer promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module ipr_core_model (
    // clock
    input wire logic core_clk,
    // toward the block
    output var logic accept_stb,
    output var ipr_pkg::ipr_accept_t accept_info,
    output var logic [ipr_pkg::IPR_NSRC-1:0] src_req
);
    import ipr_pkg::*;
    initial begin
        accept_stb = 1'b0;
        accept_info = '0;
        src_req = '0;
    end
    task automatic accept(input int gap, input logic [3:0] lvl, input logic [6:0] vec);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        accept_stb <= 1'b1;
        accept_info <= '{lvl, vec};
        @(posedge core_clk);
        accept_stb <= 1'b0;
    endtask : accept
    task automatic raise(input logic [IPR_NSRC-1:0] r);
        @(posedge core_clk);
        src_req <= r;
    endtask : raise
endmodule : ipr_core_model
`default_nettype wire

// ==== tb/ipr_regs_tb.sv ====
// Purpose: self-checking bench for ipr_regs
// Assumes: one request per task call
// Notes: built without can so those fields must stay inert
`timescale 1ns/1ps
`default_nettype none
module ipr_regs_tb;
    import ipr_pkg::*;
    localparam logic [15:0] MSK [9] = '{IPR_MASK_BANK5, IPR_MASK_BANK6, IPR_MASK_BANK7,
        IPR_MASK_BANK8, IPR_MASK_BANK9, IPR_MASK_BANK11, IPR_MASK_BANK15, IPR_MASK_BANK16,
        IPR_MASK_BANK17};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    ipr_bus_req_t bus_req = '0;
    logic [15:0] rdata;
    logic accept_stb;
    ipr_accept_t accept_info;
    logic [IPR_NSRC-1:0] src_req;
    logic [IPR_NSRC*3-1:0] src_priority;
    logic [IPR_NSRC-1:0] src_pending;
    logic [3:0] new_cpu_level;
    logic [6:0] pending_vector_number;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    ipr_core_model core (.core_clk(core_clk), .accept_stb(accept_stb),
        .accept_info(accept_info), .src_req(src_req));
    ipr_regs #(.HAS_CAN(1'b0)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus_req(bus_req), .rdata(rdata), .accept_stb(accept_stb), .accept_info(accept_info),
        .src_req(src_req), .src_priority(src_priority), .src_pending(src_pending),
        .new_cpu_level(new_cpu_level), .pending_vector_number(pending_vector_number));
    // ============================================================
    // clock, watchdog, helpers
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        bus_req <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    // ============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(4'(i), IPR_BANK_RESET & MSK[i]);
        rd(IPR_A_STATUS, IPR_STATUS_RESET);
        for (int i = 0; i < 9; i++) begin
            wr(4'(i), 16'hffff);
            rd(4'(i), MSK[i]);
        end
        // every listed source maps to a field; can and spare slots stay at zero
        for (int i = 0; i < IPR_NSRC; i++) begin
            automatic bit dead = (i >= IPR_S_CAN_EVT && i <= IPR_S_CAN_RX) || i >= 25;
            chk({13'h0, src_priority[i*3+:3]}, dead ? 16'h0000 : 16'h0007);
        end
        wr(IPR_A_STATUS, 16'hffff);
        rd(IPR_A_STATUS, IPR_STATUS_RESET);
        rd(4'hc, 16'h0000);
        core.raise('1);
        for (int c = 0; c < 8; c++) begin
            wr(IPR_A_BANK5, 16'(c) << IPR_SLOT_LSB3);
            #1 chk({13'h0, src_priority[2:0]}, 16'(c));
            chk({15'h0, src_pending[0]}, 16'(c != 0));
        end
        chk({10'h0, src_priority[3*IPR_S_CAN_EVT+:6]}, 16'h0);
        chk({15'h0, src_pending[IPR_S_CAN_TX]}, 16'h0);
        core.accept(0, 4'hf, 7'h7f);
        rd(IPR_A_STATUS, 16'h0f7f);
        chk({4'h0, new_cpu_level, 1'b0, pending_vector_number}, 16'h0f7f);
        core.accept(5, 4'h1, 7'h00);
        rd(IPR_A_STATUS, 16'h0100);
        // second reset in mid-run: written bank 8 and status must return to defaults
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(IPR_A_BANK8, IPR_BANK_RESET & IPR_MASK_BANK8);
        rd(IPR_A_STATUS, IPR_STATUS_RESET);
        finish_test();
    end
endmodule : ipr_regs_tb
`default_nettype wire
